// ===== logic/aon_consts.svh
`ifndef AON_CONSTS_SVH
`define AON_CONSTS_SVH
// Register byte addresses.
`define AON_A_HWR  32'h5000_0300
`define AON_A_STAT 32'h5000_0304
`define AON_A_RAM  32'h5000_0308
`define AON_A_PAD  32'h5000_030c
`define AON_A_HIB  32'h5000_0310
`define AON_A_PWR  32'h5000_0320
`define AON_A_GP   32'h5000_0324
// Writable bit masks; other bits read as zero.
`define AON_M_HWR  16'h0001
`define AON_M_STAT 16'h000f
`define AON_M_RAM  16'h0007
`define AON_M_PAD  16'h0001
`define AON_M_HIB  16'h007f
`define AON_M_PWR  16'h3fcf
`define AON_M_GP   16'h00ef
// Reset values.
`define AON_R_HWR  16'h0000
`define AON_R_STAT 16'h000f
`define AON_R_RAM  16'h0007
`define AON_R_PAD  16'h0001
`define AON_R_HIB  16'h0000
`define AON_R_PWR  16'h0008
`define AON_R_GP   16'h0000
// Reset cause flag positions.
`define AON_B_WDOG 3
`define AON_B_SOFT 2
`define AON_B_PIN  1
`define AON_B_POR  0
// Single control bits.
`define AON_B_PINDIS 0
`define AON_B_LATCH  0
// Hibernation control fields.
`define AON_B_HIBEN 0
`define AON_B_WPOL  1
`define AON_F_WMASK 6:2
// Supply control fields.
`define AON_F_CLAMP  13:10
`define AON_B_CMPOFF 9
`define AON_F_CONV   8:7
`define AON_B_CHGDIS 6
`define AON_B_HMASK  3
`define AON_B_LMASK  2
`define AON_F_LINK   1:0
// Analog, scratch and RAM fields.
`define AON_B_FILT   7
`define AON_B_RCXVDD 6
`define AON_B_RCXREF 5
`define AON_F_SCR    3:0
`define AON_F_RAM    2:0
// Bus responses.
`define AON_RESP_OK  2'b00
`define AON_RESP_ERR 2'b10
`endif

// ===== logic/aon_pkg.sv
package aon_pkg;
  // One register word as software sees it.
  typedef logic [15:0] aon_reg_t;
  // Converter mode codes.
  typedef enum logic [1:0] {
    AON_CONV_AUTO0 = 2'b00,
    AON_CONV_AUTO1 = 2'b01,
    AON_CONV_BUCK  = 2'b10,
    AON_CONV_BOOST = 2'b11
  } aon_conv_e;
  // Battery rail link codes.
  typedef enum logic [1:0] {
    AON_LINK_OFF   = 2'b00,
    AON_LINK_ON    = 2'b01,
    AON_LINK_SLPON = 2'b10,
    AON_LINK_AUTO  = 2'b11
  } aon_link_e;
endpackage

// ===== logic/aon_ctrl.sv
`timescale 1ns/100ps
`include "aon_consts.svh"

module aon_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        power_on_event,
  input  wire logic        watchdog_reset_event,
  input  wire logic        system_soft_reset_request,
  input  wire logic        core_reset_control_request,
  input  wire logic        reset_capable_pin,
  input  wire logic [4:0]  wakeup_pins,
  input  wire logic        sleep_active,
  input  wire logic        converter_in_boost,
  input  wire logic        por_vbat_high,
  input  wire logic        por_vbat_low,
  output logic             pin_reset_request,
  output logic [2:0]       ram_light_sleep_n,
  output logic             pad_latch_open,
  output logic             clockless_wake_status,
  output logic             hibernation_wake,
  output logic             sleep_power_domain_on,
  output logic             force_boost,
  output logic             force_buck,
  output logic             supply_reset_request,
  output logic             battery_rail_link_on,
  output logic             battery_rail_link_auto,
  output logic [3:0]       retention_clamp_level,
  output logic             sleep_comparator_off,
  output logic             high_rail_charge_en,
  output logic             pin3_pin4_filter_bypass,
  output logic             slow_osc_bias_to_core_supply,
  output logic             slow_osc_bias_to_reference
);

  // Register storage, all sixteen bits wide.
  aon_pkg::aon_reg_t hwr_q, stat_q, ram_q, pad_q, hib_q, pwr_q, gp_q;
  aon_pkg::aon_reg_t stat_d, set_v, rd_v;
  // Write channel holding state.
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q;
  logic        aw_held_q, w_held_q, bvalid_q, wr_go, wr_hit;
  // Read channel state.
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        rvalid_q, rd_hit;
  // Pin synchronisers.
  logic [4:0]  wk_s1_q, wk_s2_q;
  logic [1:0]  por_s1_q, por_s2_q;
  logic        pin_s1_q, pin_s2_q, pin_rst_prev_q, pin_rst_now;
  aon_pkg::aon_conv_e conv;
  aon_pkg::aon_link_e link;

  // Byte-lane merge of a write into a stored word.
  function automatic aon_pkg::aon_reg_t merge(
    input aon_pkg::aon_reg_t old_v,
    input logic [31:0]       new_v,
    input logic [3:0]        strb,
    input aon_pkg::aon_reg_t mask);
    aon_pkg::aon_reg_t m;
    m[7:0]  = strb[0] ? new_v[7:0] : old_v[7:0];
    m[15:8] = strb[1] ? new_v[15:8] : old_v[15:8];
    return m & mask;
  endfunction

  // Handshake outputs follow the holding flags.
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready  = ~w_held_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wr_go = aw_held_q & w_held_q & ~bvalid_q;

  // Write address decode; an unmapped address gets an error response.
  assign wr_hit = awaddr_q inside {
    `AON_A_HWR, `AON_A_STAT, `AON_A_RAM, `AON_A_PAD,
    `AON_A_HIB, `AON_A_PWR, `AON_A_GP};

  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `AON_A_HWR:  rd_v = hwr_q;
      `AON_A_STAT: rd_v = stat_q;
      `AON_A_RAM:  rd_v = ram_q;
      `AON_A_PAD:  rd_v = pad_q;
      `AON_A_HIB:  rd_v = hib_q;
      `AON_A_PWR:  rd_v = pwr_q;
      `AON_A_GP:   rd_v = gp_q;
      default: begin
        rd_v   = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Write address and data are captured in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response one cycle after both halves are held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `AON_RESP_OK;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? `AON_RESP_OK : `AON_RESP_ERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read data registered one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= `AON_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {16'h0000, rd_v};
      rresp_q  <= rd_hit ? `AON_RESP_OK : `AON_RESP_ERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Pins and analog detector lines pass two flip-flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      wk_s1_q  <= '0;
      wk_s2_q  <= '0;
      por_s1_q <= '0;
      por_s2_q <= '0;
    end else begin
      pin_s1_q <= reset_capable_pin;
      pin_s2_q <= pin_s1_q;
      wk_s1_q  <= wakeup_pins;
      wk_s2_q  <= wk_s1_q;
      por_s1_q <= {por_vbat_high, por_vbat_low};
      por_s2_q <= por_s1_q;
    end
  end

  assign pin_rst_now = pin_s2_q & ~hwr_q[`AON_B_PINDIS];

  // Edge of the gated pin reset marks one hardware reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_rst_prev_q <= 1'b0;
    end else begin
      pin_rst_prev_q <= pin_rst_now;
    end
  end

  // Flag set sources; power-on sets every flag.
  always_comb begin
    set_v = '0;
    set_v[`AON_B_WDOG] = watchdog_reset_event;
    set_v[`AON_B_SOFT] = system_soft_reset_request |
                         core_reset_control_request;
    set_v[`AON_B_PIN]  = pin_rst_now & ~pin_rst_prev_q;
    if (power_on_event) begin
      set_v = `AON_R_STAT;
    end
  end

  always_comb begin
    stat_d = stat_q;
    if (wr_go && awaddr_q == `AON_A_STAT) begin
      stat_d = merge(stat_q, wdata_q, wstrb_q, `AON_M_STAT);
    end
    stat_d = stat_d | set_v;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= `AON_R_STAT;
    end else begin
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hwr_q <= `AON_R_HWR;
      ram_q <= `AON_R_RAM;
      pad_q <= `AON_R_PAD;
      hib_q <= `AON_R_HIB;
      pwr_q <= `AON_R_PWR;
      gp_q  <= `AON_R_GP;
    end else if (wr_go) begin
      unique case (awaddr_q)
        `AON_A_HWR:
          hwr_q <= merge(hwr_q, wdata_q, wstrb_q, `AON_M_HWR);
        `AON_A_RAM:
          ram_q <= merge(ram_q, wdata_q, wstrb_q, `AON_M_RAM);
        `AON_A_PAD:
          pad_q <= merge(pad_q, wdata_q, wstrb_q, `AON_M_PAD);
        `AON_A_HIB:
          hib_q <= merge(hib_q, wdata_q, wstrb_q, `AON_M_HIB);
        `AON_A_PWR:
          pwr_q <= merge(pwr_q, wdata_q, wstrb_q, `AON_M_PWR);
        `AON_A_GP:
          gp_q  <= merge(gp_q, wdata_q, wstrb_q, `AON_M_GP);
        default: ;
      endcase
    end
  end

  assign conv = aon_pkg::aon_conv_e'(pwr_q[`AON_F_CONV]);
  assign link = aon_pkg::aon_link_e'(pwr_q[`AON_F_LINK]);

  // Control outputs registered from the fields and live inputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_reset_request            <= 1'b0;
      ram_light_sleep_n            <= 3'h7;
      pad_latch_open               <= 1'b1;
      clockless_wake_status        <= 1'b1;
      hibernation_wake             <= 1'b0;
      sleep_power_domain_on        <= 1'b1;
      force_boost                  <= 1'b0;
      force_buck                   <= 1'b0;
      supply_reset_request         <= 1'b0;
      battery_rail_link_on         <= 1'b0;
      battery_rail_link_auto       <= 1'b0;
      retention_clamp_level        <= 4'h0;
      sleep_comparator_off         <= 1'b0;
      high_rail_charge_en          <= 1'b1;
      pin3_pin4_filter_bypass      <= 1'b0;
      slow_osc_bias_to_core_supply <= 1'b0;
      slow_osc_bias_to_reference   <= 1'b0;
    end else begin
      pin_reset_request <= pin_rst_now;
      ram_light_sleep_n <= ram_q[`AON_F_RAM];
      pad_latch_open <= pad_q[`AON_B_LATCH];
      clockless_wake_status <= ~|((wk_s2_q ^ {5{hib_q[`AON_B_WPOL]}})
                                  & hib_q[`AON_F_WMASK]);
      hibernation_wake <= sleep_active & hib_q[`AON_B_HIBEN] &
                          |((wk_s2_q ^ {5{hib_q[`AON_B_WPOL]}})
                            & hib_q[`AON_F_WMASK]);
      sleep_power_domain_on <= ~(sleep_active & hib_q[`AON_B_HIBEN]);
      force_boost <= (conv == aon_pkg::AON_CONV_BOOST);
      force_buck  <= (conv == aon_pkg::AON_CONV_BUCK);
      supply_reset_request <= (por_s2_q[1] & ~pwr_q[`AON_B_HMASK]) |
                              (por_s2_q[0] & ~pwr_q[`AON_B_LMASK]);
      battery_rail_link_on <= (link == aon_pkg::AON_LINK_ON) |
        ((link == aon_pkg::AON_LINK_SLPON) & sleep_active);
      battery_rail_link_auto <= (link == aon_pkg::AON_LINK_AUTO) |
        ((link == aon_pkg::AON_LINK_SLPON) & ~sleep_active);
      retention_clamp_level <= pwr_q[`AON_F_CLAMP];
      sleep_comparator_off <= pwr_q[`AON_B_CMPOFF] & sleep_active;
      high_rail_charge_en <= ~(pwr_q[`AON_B_CHGDIS] & converter_in_boost);
      pin3_pin4_filter_bypass <= gp_q[`AON_B_FILT];
      slow_osc_bias_to_core_supply <= gp_q[`AON_B_RCXVDD];
      slow_osc_bias_to_reference   <= gp_q[`AON_B_RCXREF];
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Sequences for the write path and the pin reset path.
  sequence stat_clear_write;
    wr_go && awaddr_q == `AON_A_STAT && wstrb_q[0] && wdata_q[3:0] == 4'h0;
  endsequence
  sequence pin_asserted;
    !pin_s2_q ##1 pin_s2_q && !hwr_q[`AON_B_PINDIS];
  endsequence

  power_on_flags_a: assert property (
    power_on_event |=> stat_q[3:0] == 4'hf)
    else $error("power-on did not set all flags");
  watchdog_flag_a: assert property (
    watchdog_reset_event |=> stat_q[`AON_B_WDOG])
    else $error("watchdog flag not set");
  soft_flag_a: assert property (
    (system_soft_reset_request || core_reset_control_request)
      |=> stat_q[`AON_B_SOFT])
    else $error("software flag not set");
  pin_flag_a: assert property (
    pin_asserted ##0 $stable(hwr_q) |=> stat_q[`AON_B_PIN])
    else $error("pin flag not set");
  pin_disable_a: assert property (
    hwr_q[`AON_B_PINDIS] |=> !pin_reset_request)
    else $error("pin reset passed while disabled");
  flag_clear_a: assert property (
    stat_clear_write ##0 (set_v[3:0] == 4'h0) |=> stat_q[3:0] == 4'h0)
    else $error("flag write did not clear");
  ram_follow_a: assert property (
    ##2 ram_light_sleep_n == $past(ram_q[2:0], 1))
    else $error("ram light sleep mismatch");
  domain_off_a: assert property (
    (sleep_active && hib_q[`AON_B_HIBEN]) |=> !sleep_power_domain_on)
    else $error("sleep domain stayed on in hibernation");
  boost_force_a: assert property (
    pwr_q[8:7] == 2'b11 |=> force_boost && !force_buck)
    else $error("boost not forced");
  reserved_zero_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 &&
      (pwr_q & ~`AON_M_PWR) == 16'h0000)
    else $error("reserved bits not zero");

endmodule // aon_ctrl

// ===== verif/test_always_on_power_reset_ctrl.sv
`timescale 1ns/100ps
`include "aon_consts.svh"

module test_always_on_power_reset_ctrl;
  logic        aclk, aresetn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        power_on_event, watchdog_reset_event;
  logic        system_soft_reset_request, core_reset_control_request;
  logic        reset_capable_pin, sleep_active, converter_in_boost;
  logic [4:0]  wakeup_pins;
  logic        por_vbat_high, por_vbat_low, pin_reset_request;
  logic [2:0]  ram_light_sleep_n;
  logic        pad_latch_open, clockless_wake_status, hibernation_wake;
  logic        sleep_power_domain_on, force_boost, force_buck;
  logic        supply_reset_request, battery_rail_link_on;
  logic        battery_rail_link_auto, sleep_comparator_off;
  logic [3:0]  retention_clamp_level;
  logic        high_rail_charge_en, pin3_pin4_filter_bypass;
  logic        slow_osc_bias_to_core_supply, slow_osc_bias_to_reference;
  int          n_fail, checks;

  localparam logic [31:0] ADR [7] = '{`AON_A_HWR, `AON_A_STAT, `AON_A_RAM,
    `AON_A_PAD, `AON_A_HIB, `AON_A_PWR, `AON_A_GP};
  localparam logic [15:0] RST [7] = '{`AON_R_HWR, `AON_R_STAT, `AON_R_RAM,
    `AON_R_PAD, `AON_R_HIB, `AON_R_PWR, `AON_R_GP};
  localparam logic [15:0] MSK [7] = '{`AON_M_HWR, `AON_M_STAT, `AON_M_RAM,
    `AON_M_PAD, `AON_M_HIB, `AON_M_PWR, `AON_M_GP};
  localparam logic [3:0]  FLG [4] = '{4'h8, 4'h4, 4'h4, 4'hf};

  aon_ctrl dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .power_on_event(power_on_event),
    .watchdog_reset_event(watchdog_reset_event),
    .system_soft_reset_request(system_soft_reset_request),
    .core_reset_control_request(core_reset_control_request),
    .reset_capable_pin(reset_capable_pin), .wakeup_pins(wakeup_pins),
    .sleep_active(sleep_active), .converter_in_boost(converter_in_boost),
    .por_vbat_high(por_vbat_high), .por_vbat_low(por_vbat_low),
    .pin_reset_request(pin_reset_request),
    .ram_light_sleep_n(ram_light_sleep_n), .pad_latch_open(pad_latch_open),
    .clockless_wake_status(clockless_wake_status),
    .hibernation_wake(hibernation_wake),
    .sleep_power_domain_on(sleep_power_domain_on),
    .force_boost(force_boost), .force_buck(force_buck),
    .supply_reset_request(supply_reset_request),
    .battery_rail_link_on(battery_rail_link_on),
    .battery_rail_link_auto(battery_rail_link_auto),
    .retention_clamp_level(retention_clamp_level),
    .sleep_comparator_off(sleep_comparator_off),
    .high_rail_charge_en(high_rail_charge_en),
    .pin3_pin4_filter_bypass(pin3_pin4_filter_bypass),
    .slow_osc_bias_to_core_supply(slow_osc_bias_to_core_supply),
    .slow_osc_bias_to_reference(slow_osc_bias_to_reference)
  );

  // Free-running system clock at 50 MHz.
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic results;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Compares one value and counts a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write cycle; address and data are released as each is taken.
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  // Read cycle; data and response are compared at the taking edge.
  task automatic rd(input logic [31:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  // Lets synchronisers and output flops catch up.
  task automatic settle;
    repeat (6) @(posedge aclk);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 7; i++) rd(ADR[i], 32'(RST[i]), `AON_RESP_OK);
    chk({ram_light_sleep_n, pad_latch_open, sleep_power_domain_on,
         high_rail_charge_en, pin_reset_request}, 32'h7e);
  endtask

  // writable bits, reserved bits, unmapped address.
  task automatic t_masks;
    for (int i = 0; i < 7; i++) begin
      wr(ADR[i], 32'hffff_ffff, `AON_RESP_OK);
      rd(ADR[i], 32'(MSK[i]), `AON_RESP_OK);
      wr(ADR[i], 32'h0, `AON_RESP_OK);
      rd(ADR[i], 32'h0, `AON_RESP_OK);
    end
    wr(32'h5000_0314, 32'hffff_ffff, `AON_RESP_ERR);
    rd(32'h5000_0314, 32'h0, `AON_RESP_ERR);
    wr(`AON_A_PAD, 32'h1, `AON_RESP_OK);
  endtask

  // each cause sets its flag after a clear; both soft causes share one flag, power-on sets all four.
  task automatic t_flags;
    for (int i = 0; i < 4; i++) begin
      wr(`AON_A_STAT, 32'h0, `AON_RESP_OK);
      rd(`AON_A_STAT, 32'h0, `AON_RESP_OK);
      case (i)
        0: watchdog_reset_event <= 1'b1;
        1: system_soft_reset_request <= 1'b1;
        2: core_reset_control_request <= 1'b1;
        default: power_on_event <= 1'b1;
      endcase
      @(posedge aclk);
      watchdog_reset_event <= 1'b0;
      system_soft_reset_request <= 1'b0;
      core_reset_control_request <= 1'b0;
      power_on_event <= 1'b0;
      @(posedge aclk);
      rd(`AON_A_STAT, 32'(FLG[i]), `AON_RESP_OK);
    end
  endtask

  // pin reset ignored while disabled, flagged once enabled.
  task automatic t_pin;
    wr(`AON_A_HWR, 32'h1, `AON_RESP_OK);
    wr(`AON_A_STAT, 32'h0, `AON_RESP_OK);
    reset_capable_pin <= 1'b1;
    settle;
    chk(32'(pin_reset_request), 32'h0);
    rd(`AON_A_STAT, 32'h0, `AON_RESP_OK);
    wr(`AON_A_HWR, 32'h0, `AON_RESP_OK);
    settle;
    chk(32'(pin_reset_request), 32'h1);
    rd(`AON_A_STAT, 32'h2, `AON_RESP_OK);
    reset_capable_pin <= 1'b0;
    settle;
    chk(32'(pin_reset_request), 32'h0);
    // A fresh rise of the pin while enabled must set the flag again.
    wr(`AON_A_STAT, 32'h0, `AON_RESP_OK);
    reset_capable_pin <= 1'b1;
    settle;
    rd(`AON_A_STAT, 32'h2, `AON_RESP_OK);
    reset_capable_pin <= 1'b0;
  endtask

  // plain control bits reach their outputs.
  task automatic t_bits;
    wr(`AON_A_RAM, 32'h2, `AON_RESP_OK);
    wr(`AON_A_PAD, 32'h0, `AON_RESP_OK);
    wr(`AON_A_GP, 32'ha5, `AON_RESP_OK);
    settle;
    chk({ram_light_sleep_n, pad_latch_open}, 32'h4);
    chk({pin3_pin4_filter_bypass, slow_osc_bias_to_core_supply,
         slow_osc_bias_to_reference}, 32'h5);
    rd(`AON_A_GP, 32'ha5, `AON_RESP_OK);
    wr(`AON_A_PAD, 32'h1, `AON_RESP_OK);
  endtask

  // supply field decode, active and asleep.
  task automatic t_supply;
    logic [31:0] v;
    logic [31:0] e;
    por_vbat_high <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 4; i++) begin
        v = ((i * 3 + 1) << 10) | 32'h248 | (i << 7) | i;
        sleep_active <= s[0];
        converter_in_boost <= s[0];
        por_vbat_low <= s[0];
        wr(`AON_A_PWR, v, `AON_RESP_OK);
        settle;
        e = {i == 3, i == 2, i == 1 || (i == 2 && s == 1),
             i == 3 || (i == 2 && s == 0), 4'(i * 3 + 1), s[0], !s[0],
             s[0]};
        chk({force_boost, force_buck, battery_rail_link_on,
             battery_rail_link_auto, retention_clamp_level,
             sleep_comparator_off, high_rail_charge_en,
             supply_reset_request}, e);
      end
    end
    wr(`AON_A_PWR, 32'h4, `AON_RESP_OK);
    por_vbat_low <= 1'b0;
    settle;
    chk(32'(supply_reset_request), 32'h1);
    por_vbat_high <= 1'b0;
    sleep_active <= 1'b0;
    converter_in_boost <= 1'b0;
    wr(`AON_A_PWR, 32'h8, `AON_RESP_OK);
  endtask

  // wake on a selected pin only, domain off in hibernation.
  task automatic t_hib;
    // polarity programmed so that the status reads one.
    wr(`AON_A_HIB, 32'h7, `AON_RESP_OK);
    wakeup_pins <= 5'b00001;
    sleep_active <= 1'b1;
    settle;
    chk({clockless_wake_status, hibernation_wake, sleep_power_domain_on},
        32'h4);
    wakeup_pins <= 5'b10001;
    settle;
    chk({clockless_wake_status, hibernation_wake}, 32'h2);
    wakeup_pins <= 5'b10000;
    settle;
    chk({clockless_wake_status, hibernation_wake}, 32'h1);
    wr(`AON_A_HIB, 32'h6, `AON_RESP_OK);
    settle;
    chk({hibernation_wake, sleep_power_domain_on}, 32'h1);
    sleep_active <= 1'b0;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    results;
  end

  // Main sequence: reset, then each scenario in turn.
  initial begin
    n_fail = 0;
    checks = 0;
    aresetn = 1'b0;
    s_axi_awaddr = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 32'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    {power_on_event, watchdog_reset_event} = 2'b00;
    {system_soft_reset_request, core_reset_control_request} = 2'b00;
    {reset_capable_pin, sleep_active, converter_in_boost} = 3'b000;
    {por_vbat_high, por_vbat_low} = 2'b00;
    wakeup_pins = 5'h00;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset;
    t_masks;
    t_flags;
    t_pin;
    t_bits;
    t_supply;
    t_hib;
    results;
  end
endmodule // test_always_on_power_reset_ctrl
